//--- shared/dsg_pkg.sv
/*
 * Constants for the deep-sleep unit clock gating block: register map,
 * field positions, reset values and the power-mode encoding.
 * Assumes a 32-bit register port addressed with full byte addresses.
 */
`default_nettype none

package dsg_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [31:0] DSG_BASE_ADDR      = 32'h400F_E000;
	localparam logic [11:0] DSG_RUN_CFG_OFS    = 12'h060;  // run_clock_config
	localparam logic [11:0] DSG_RUN_GATE_OFS   = 12'h100;  // run_gate_reg
	localparam logic [11:0] DSG_SLEEP_GATE_OFS = 12'h110;  // sleep_gate_reg
	localparam logic [11:0] DSG_DEEP_GATE_OFS  = 12'h120;  // deep_sleep_gate_reg

	// ------------------------------------------------------------------
	// gating register fields, identical in all three gating registers
	// ------------------------------------------------------------------
	localparam int DSG_NUM_UNITS = 4;
	localparam int DSG_WDT_BIT   = 3;   // watchdog_clock_en
	localparam int DSG_KEEP_BIT  = 6;   // low_power_keeper_clock_en
	localparam int DSG_ADC_BIT   = 16;  // converter clock enable
	localparam int DSG_CAN_BIT   = 24;  // bus_controller_clock_en

	localparam logic [31:0] DSG_GATE_MASK  = 32'h0101_0048;
	localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0040;

	// run_clock_config: only the auto_clock_gating bit is kept here
	localparam int          DSG_ACG_BIT       = 27;
	localparam logic [31:0] DSG_RUN_CFG_MASK  = 32'h0800_0000;
	localparam logic [31:0] DSG_RUN_CFG_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------
	// power mode, gray along run -> sleep -> deep-sleep
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DSG_RUN   = 2'h0,
		DSG_SLEEP = 2'h1,
		DSG_DEEP  = 2'h3
	} dsg_mode_t;

endpackage

`default_nettype wire

//--- rtl/dsg_clock_gate.sv
/*
 * One glitch-free clock gate cell: the enable is taken on the falling
 * edge so that the and-gate only changes while the clock is low.
 * Assumes CLOCK is the free-running system clock.
 */
`default_nettype none

module dsg_clock_gate #(
	parameter logic EN_RESET = 1'b0        // enable value during reset
) (
	input  wire logic CLOCK,               // system clock
	input  wire logic RSTN,                // synchronous reset, active low
	input  wire logic en,                  // requested enable
	output logic      en_q,                // enable as applied to the unit
	output logic      gclk                 // gated clock to the unit
);

	// ------------------------------------------------------------------
	// enable capture on the low phase
	// ------------------------------------------------------------------
	// a falling-edge flop keeps the gated clock free of runt pulses
	always_ff @(negedge CLOCK) begin
		if (!RSTN) begin
			en_q <= EN_RESET;
		end else begin
			en_q <= en;
		end
	end

	assign gclk = CLOCK & en_q;

endmodule

`default_nettype wire

//--- rtl/dsg_gating.sv
/*
 * Unit clock gating controller: run, sleep and deep-sleep gating
 * registers, the auto gating switch, per-unit gated clocks and the
 * bus fault answer for accesses to unclocked units.
 * Assumes one system clock, a one-cycle-strobe register port and
 * peripheral access strobes sampled on the same clock.
 */
// Operation
// - in deep-sleep with auto gating set, each deep-sleep gating bit is the clock enable of its unit
// - access to an unclocked unit is answered with a bus fault
// - deep-sleep gating register resets to 0x00000040
// - run, sleep and deep-sleep gating registers share one layout
// - sleep and deep-sleep gating only apply with auto gating set
// - bit 24 enables the bus controller clock, resets to zero
// - bit 16 enables the converter clock; unclocked access faults
// - bit 6 enables the low-power keeper clock, resets to one
// - bit 3 enables the watchdog clock; unclocked access faults
// - unused bits read zero, ignore writes; software preserves them
// - deep-sleep gating register decodes at base plus 0x120
`default_nettype none

module dsg_gating
	import dsg_pkg::*;
(
	input  wire logic        CLOCK,           // system clock, 20 MHz
	input  wire logic        RSTN,            // synchronous reset, active low
	input  wire logic [31:0] ADDR,            // register byte address
	input  wire logic [31:0] WDATA,           // register write data
	input  wire logic        WRITE,           // write strobe
	input  wire logic        READ,            // read strobe
	output logic      [31:0] RDATA,           // read data, cycle after READ
	input  wire logic        SLEEP_REQ,       // processor is in sleep
	input  wire logic        DEEP_SLEEP_REQ,  // processor is in deep-sleep
	input  wire logic [3:0]  UNIT_ACCESS,     // bus access per unit
	output logic      [3:0]  UNIT_FAULT,      // bus fault per unit
	output logic      [3:0]  UNIT_CLK_EN,     // applied clock enable per unit
	output logic      [3:0]  UNIT_CLK         // gated clock per unit
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [31:0] run_gate_q;
	logic [31:0] sleep_gate_q;
	logic [31:0] deep_gate_q;
	logic [31:0] run_cfg_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] sel_gate;
	logic [3:0]  unit_req;
	logic        hit_run_cfg;
	logic        hit_run_gate;
	logic        hit_sleep_gate;
	logic        hit_deep_gate;
	logic        auto_clock_gating;
	dsg_mode_t   mode_q;
	dsg_mode_t   mode_d;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	assign hit_run_cfg    = (ADDR == DSG_BASE_ADDR + {20'h0_0000, DSG_RUN_CFG_OFS});
	assign hit_run_gate   = (ADDR == DSG_BASE_ADDR + {20'h0_0000, DSG_RUN_GATE_OFS});
	assign hit_sleep_gate = (ADDR == DSG_BASE_ADDR + {20'h0_0000, DSG_SLEEP_GATE_OFS});
	assign hit_deep_gate  = (ADDR == DSG_BASE_ADDR + {20'h0_0000, DSG_DEEP_GATE_OFS});

	// ------------------------------------------------------------------
	// gating registers
	// ------------------------------------------------------------------
	// all three share one mask and reset value, so they stay comparable
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			run_gate_q   <= DSG_GATE_RESET;
			sleep_gate_q <= DSG_GATE_RESET;
		end else if (WRITE && hit_run_gate) begin
			run_gate_q   <= WDATA & DSG_GATE_MASK;
		end else if (WRITE && hit_sleep_gate) begin
			sleep_gate_q <= WDATA & DSG_GATE_MASK;
		end
	end

	// deep-sleep register: keeper bit comes out of reset set
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			deep_gate_q <= DSG_GATE_RESET;
		end else if (WRITE && hit_deep_gate) begin
			deep_gate_q <= WDATA & DSG_GATE_MASK;
		end
	end

	// auto gating switch, the only bit of run_clock_config kept here
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			run_cfg_q <= DSG_RUN_CFG_RESET;
		end else if (WRITE && hit_run_cfg) begin
			run_cfg_q <= WDATA & DSG_RUN_CFG_MASK;
		end
	end

	assign auto_clock_gating = run_cfg_q[DSG_ACG_BIT];

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	// unmapped addresses read zero; data stands for exactly one cycle
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_run_cfg) begin
			rdata_d = run_cfg_q;
		end else if (hit_run_gate) begin
			rdata_d = run_gate_q;
		end else if (hit_sleep_gate) begin
			rdata_d = sleep_gate_q;
		end else if (hit_deep_gate) begin
			rdata_d = deep_gate_q;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			rdata_q <= 32'h0000_0000;
		end else if (READ) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign RDATA = rdata_q;

	// ------------------------------------------------------------------
	// power mode tracking
	// ------------------------------------------------------------------
	// deep-sleep wins when both requests are seen together
	always_comb begin
		mode_d = DSG_RUN;
		case (mode_q)
			DSG_RUN: begin
				if (DEEP_SLEEP_REQ) begin
					mode_d = DSG_DEEP;
				end else if (SLEEP_REQ) begin
					mode_d = DSG_SLEEP;
				end
			end
			DSG_SLEEP: begin
				if (DEEP_SLEEP_REQ) begin
					mode_d = DSG_DEEP;
				end else if (SLEEP_REQ) begin
					mode_d = DSG_SLEEP;
				end
			end
			DSG_DEEP: begin
				if (DEEP_SLEEP_REQ) begin
					mode_d = DSG_DEEP;
				end else if (SLEEP_REQ) begin
					mode_d = DSG_SLEEP;
				end
			end
			default: mode_d = DSG_RUN;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			mode_q <= DSG_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ------------------------------------------------------------------
	// gating source selection
	// ------------------------------------------------------------------
	// without auto gating the run register holds in every mode
	always_comb begin
		sel_gate = run_gate_q;
		if (auto_clock_gating && mode_q == DSG_DEEP) begin
			sel_gate = deep_gate_q;
		end else if (auto_clock_gating && mode_q == DSG_SLEEP) begin
			sel_gate = sleep_gate_q;
		end
	end

	assign unit_req[0] = sel_gate[DSG_WDT_BIT];
	assign unit_req[1] = sel_gate[DSG_KEEP_BIT];
	assign unit_req[2] = sel_gate[DSG_ADC_BIT];
	assign unit_req[3] = sel_gate[DSG_CAN_BIT];

	// ------------------------------------------------------------------
	// per-unit gate cells
	// ------------------------------------------------------------------
	// keeper cell resets enabled so that unit keeps its clock through reset
	for (genvar u = 0; u < DSG_NUM_UNITS; u++) begin : g_unit
		dsg_clock_gate #(
			.EN_RESET (u == 1)
		) u_gate (
			.CLOCK (CLOCK),
			.RSTN  (RSTN),
			.en    (unit_req[u]),
			.en_q  (UNIT_CLK_EN[u]),
			.gclk  (UNIT_CLK[u])
		);
	end

	// fault follows the applied enable, so it matches what the unit sees
	assign UNIT_FAULT = UNIT_ACCESS & ~UNIT_CLK_EN;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	sequence s_deep_write;
		WRITE && hit_deep_gate;
	endsequence

	sequence s_deep_read;
		READ && hit_deep_gate;
	endsequence

	chk_reset_value: assert property (
		disable iff (1'b0) !RSTN |=> deep_gate_q == 32'h0000_0040)
		else $error("deep gating register wrong after reset");

	chk_keeper_reset: assert property (
		disable iff (1'b0) !RSTN ##1 !RSTN |=> UNIT_CLK_EN[1] && !UNIT_CLK_EN[0])
		else $error("keeper enable not set after reset");

	chk_write_readback: assert property (
		s_deep_write ##1 s_deep_read |=>
			RDATA == ($past(WDATA, 2) & 32'h0101_0048))
		else $error("deep gating readback wrong");

	chk_reserved_zero: assert property (
		READ |=> (RDATA & 32'hFEFE_FFB7) == 32'h0000_0000 || !$past(hit_deep_gate))
		else $error("reserved bits not zero");

	chk_deep_select: assert property (
		auto_clock_gating && mode_q == DSG_DEEP |->
			UNIT_CLK_EN[3] == deep_gate_q[DSG_CAN_BIT] &&
			UNIT_CLK_EN[2] == deep_gate_q[DSG_ADC_BIT] &&
			UNIT_CLK_EN[0] == deep_gate_q[DSG_WDT_BIT])
		else $error("deep-sleep enables not applied");

	chk_run_select: assert property (
		!auto_clock_gating |-> UNIT_CLK_EN[0] == run_gate_q[DSG_WDT_BIT])
		else $error("run register not applied");

	chk_sleep_auto: assert property (
		auto_clock_gating && mode_q == DSG_SLEEP |-> UNIT_CLK_EN == {sleep_gate_q[DSG_CAN_BIT],
			sleep_gate_q[DSG_ADC_BIT], sleep_gate_q[DSG_KEEP_BIT], sleep_gate_q[DSG_WDT_BIT]})
		else $error("sleep register not applied");

	chk_fault_answer: assert property (
		UNIT_ACCESS[2] && !UNIT_CLK_EN[2] |-> UNIT_FAULT[2])
		else $error("no fault on unclocked converter");

	chk_fault_clocked: assert property (
		UNIT_CLK_EN[0] |-> !UNIT_FAULT[0])
		else $error("fault on clocked watchdog");

	chk_unmapped_read: assert property (
		READ && !(hit_run_cfg || hit_run_gate || hit_sleep_gate || hit_deep_gate)
			|=> RDATA == 32'h0000_0000)
		else $error("unmapped read not zero");

	// mode tracking: each request is taken at the edge that samples it
	sequence s_deep_req;
		DEEP_SLEEP_REQ;
	endsequence

	sequence s_sleep_only;
		SLEEP_REQ && !DEEP_SLEEP_REQ;
	endsequence

	chk_mode_deep: assert property (
		s_deep_req |=> mode_q == DSG_DEEP)
		else $error("deep-sleep request not tracked");

	chk_mode_sleep: assert property (
		s_sleep_only |=> mode_q == DSG_SLEEP)
		else $error("sleep request not tracked");

	chk_mode_run: assert property (
		!SLEEP_REQ && !DEEP_SLEEP_REQ |=> mode_q == DSG_RUN)
		else $error("return to run not tracked");

	// other writes must leave the deep-sleep register alone
	chk_write_ignored: assert property (
		WRITE && !hit_deep_gate |=> $stable(deep_gate_q))
		else $error("deep gating register changed by foreign write");

	chk_fault_bus_ctrl: assert property (
		UNIT_ACCESS[3] && !UNIT_CLK_EN[3] |-> UNIT_FAULT[3])
		else $error("no fault on unclocked bus controller");

	// sampled on the falling edge, where the gated clock shows its enable
	chk_gated_clock: assert property (
		@(negedge CLOCK) UNIT_CLK == UNIT_CLK_EN)
		else $error("gated clock does not follow its enable");

endmodule

`default_nettype wire

//--- test/dsg_unit_model.sv
/*
 * Far-side model: the gated peripheral units. Each counts the edges of
 * its own gated clock and raises a bus access when the bench pokes it.
 * Assumes UNIT_CLK comes straight from the gating block.
 */
`default_nettype none

module dsg_unit_model (
	input  wire logic [3:0]  UNIT_CLK,     // gated clock per unit
	input  wire logic [3:0]  poke,         // bench asks unit to be accessed
	output logic      [3:0]  UNIT_ACCESS,  // bus access per unit
	output logic      [31:0] ticks         // 8-bit edge count per unit
);
	timeunit 1ns;
	timeprecision 1ns;

	// an unclocked unit cannot count, which is what the bench looks for
	for (genvar i = 0; i < 4; i++) begin : g_unit
		logic [7:0] cnt_q = 8'h00;
		always @(posedge UNIT_CLK[i]) cnt_q <= cnt_q + 8'h01;
		assign ticks[8*i +: 8] = cnt_q;
	end

	// bus accesses are only as wide as the bench's request
	assign UNIT_ACCESS = poke;
endmodule

`default_nettype wire

//--- test/tb_top.sv
/*
 * Self-checking bench for the unit clock gating block.
 * Assumes the register port answers reads one cycle after the strobe.
 */
`default_nettype none

module tb_top;
	import dsg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        CLOCK, RSTN, WRITE, READ, SLEEP_REQ, DEEP_SLEEP_REQ;
	logic [31:0] ADDR, WDATA, RDATA, TICKS;
	logic [3:0]  POKE, UNIT_ACCESS, UNIT_FAULT, UNIT_CLK_EN, UNIT_CLK;
	int          n_fail, compares;

	dsg_gating u_dsg_gating (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
		.WRITE(WRITE), .READ(READ), .RDATA(RDATA), .SLEEP_REQ(SLEEP_REQ),
		.DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .UNIT_ACCESS(UNIT_ACCESS),
		.UNIT_FAULT(UNIT_FAULT), .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_CLK(UNIT_CLK));
	dsg_unit_model u_dsg_unit_model (.UNIT_CLK(UNIT_CLK), .poke(POKE),
		.UNIT_ACCESS(UNIT_ACCESS), .ticks(TICKS));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// 20 MHz system clock
	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] at(logic [11:0] ofs);
		return DSG_BASE_ADDR | {20'h00000, ofs};
	endfunction

	// one-cycle write strobe
	task automatic wr(logic [11:0] ofs, logic [31:0] d);
		@(posedge CLOCK);
		ADDR  <= at(ofs);
		WDATA <= d;
		WRITE <= 1'b1;
		@(posedge CLOCK);
		WRITE <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(logic [11:0] ofs, output logic [31:0] d);
		@(posedge CLOCK);
		ADDR <= at(ofs);
		READ <= 1'b1;
		@(posedge CLOCK);
		READ <= 1'b0;
		#1 d = RDATA;
	endtask

	// write then read back with no gap between the two strobes
	task automatic wr_rd(logic [11:0] ofs, logic [31:0] wd, output logic [31:0] d);
		@(posedge CLOCK);
		ADDR  <= at(ofs);
		WDATA <= wd;
		WRITE <= 1'b1;
		@(posedge CLOCK);
		WRITE <= 1'b0;
		READ  <= 1'b1;
		@(posedge CLOCK);
		READ <= 1'b0;
		#1 d = RDATA;
	endtask

	// enables follow a mode change at the falling edge after it registers
	task automatic mode(logic s, logic d);
		@(posedge CLOCK);
		SLEEP_REQ      <= s;
		DEEP_SLEEP_REQ <= d;
		repeat (3) @(posedge CLOCK);
		#1;
	endtask

	// clocked units see exactly ten edges in ten cycles, others none
	task automatic ticks_chk(logic [3:0] en);
		logic [31:0] t0;
		logic [7:0]  dt;
		t0 = TICKS;
		repeat (10) @(posedge CLOCK);
		#1;
		// counts wrap at 8 bits, so the difference is taken at 8 bits
		for (int i = 0; i < 4; i++) begin
			dt = TICKS[8*i +: 8] - t0[8*i +: 8];
			chk("unit ticks", 32'(dt), en[i] ? 32'h0000000A : 32'h00000000);
		end
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		rd(DSG_DEEP_GATE_OFS, d);
		chk("deep reset", d, 32'h00000040);
		rd(DSG_SLEEP_GATE_OFS, d);
		chk("sleep reset", d, 32'h00000040);
		rd(DSG_RUN_GATE_OFS, d);
		chk("run reset", d, 32'h00000040);
		rd(DSG_RUN_CFG_OFS, d);
		chk("cfg reset", d, 32'h00000000);
		chk("enables after reset", 32'(UNIT_CLK_EN), 32'h00000002);
		$display("test reset done");
	endtask

	task automatic t_fields();
		logic [31:0] d;
		wr(DSG_DEEP_GATE_OFS, 32'hFFFFFFFF);
		rd(DSG_DEEP_GATE_OFS, d);
		chk("deep all ones", d, 32'h01010048);
		wr_rd(DSG_DEEP_GATE_OFS, 32'hA5A5A5A5, d);
		chk("deep back to back", d, 32'h01010000);
		wr(DSG_DEEP_GATE_OFS, 32'h00000000);
		rd(DSG_DEEP_GATE_OFS, d);
		chk("deep all zero", d, 32'h00000000);
		rd(12'h124, d);
		chk("unmapped read", d, 32'h00000000);
		$display("test fields done");
	endtask

	task automatic t_modes();
		logic [31:0] d;
		rd(DSG_RUN_GATE_OFS, d);
		wr(DSG_RUN_GATE_OFS, (d & ~DSG_GATE_MASK) | 32'h00000008);
		wr(DSG_DEEP_GATE_OFS, 32'h01000008);
		wr(DSG_SLEEP_GATE_OFS, 32'h00010040);
		mode(1'b0, 1'b1);
		chk("deep without auto", 32'(UNIT_CLK_EN), 32'h00000001);
		wr(DSG_RUN_CFG_OFS, 32'h08000000);
		@(posedge CLOCK);
		POKE <= 4'hF;
		@(posedge CLOCK);
		#1;
		chk("deep enables", 32'(UNIT_CLK_EN), 32'h00000009);
		chk("deep faults", 32'(UNIT_FAULT), 32'h00000006);
		ticks_chk(4'b1001);
		mode(1'b1, 1'b0);
		chk("sleep enables", 32'(UNIT_CLK_EN), 32'h00000006);
		chk("sleep faults", 32'(UNIT_FAULT), 32'h00000009);
		mode(1'b1, 1'b1);
		chk("deep wins", 32'(UNIT_CLK_EN), 32'h00000009);
		mode(1'b0, 1'b0);
		chk("run enables", 32'(UNIT_CLK_EN), 32'h00000001);
		chk("run faults", 32'(UNIT_FAULT), 32'h0000000E);
		ticks_chk(4'b0001);
		@(posedge CLOCK);
		POKE <= 4'h0;
		$display("test modes done");
	endtask

	// reset again in mid-run: every register must fall back to its reset value
	task automatic t_mid_reset();
		@(posedge CLOCK);
		RSTN <= 1'b0;
		repeat (4) @(posedge CLOCK);
		RSTN <= 1'b1;
		t_reset();
		$display("test mid reset done");
	endtask

	// ------------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge CLOCK);
		n_fail++;
		end_sim();
	end

	initial begin
		RSTN = 1'b0;
		WRITE = 1'b0;
		READ = 1'b0;
		ADDR = 32'h00000000;
		WDATA = 32'h00000000;
		SLEEP_REQ = 1'b0;
		DEEP_SLEEP_REQ = 1'b0;
		POKE = 4'h0;
		n_fail = 0;
		compares = 0;
		repeat (4) @(posedge CLOCK);
		RSTN <= 1'b1;
		t_reset();
		t_fields();
		t_modes();
		t_mid_reset();
		end_sim();
	end
endmodule

`default_nettype wire
